// >>> oscillator_clock_divider.sv
// Internal oscillator, config clock and two ratio dividers behind an APB slave
//
// The placing of the registers and the APB interface to the registers were decided locally.
`default_nettype none
module ratio_divider (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [15:0] halfCount,
  output logic divClk
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic next_divClk;

  always_comb begin
    next_count = count;
    next_divClk = divClk;
    if (tick) begin
      if (count >= halfCount) begin // R9
        next_count = 16'h0000;
        next_divClk = ~divClk;
      end else begin
        next_count = count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000; // R9
      divClk <= 1'b0;
    end else begin
      count <= next_count;
      divClk <= next_divClk;
    end
  end

  AST_DIV_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n) // R9
    tick && count >= halfCount |=> divClk != $past(divClk) && count == 16'h0000)
    else $error("divided clock did not toggle at half ratio");
  AST_DIV_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R4
    !tick |=> $stable(count) && $stable(divClk))
    else $error("divider moved without a source tick");
endmodule : ratio_divider

// Behaviour
// R1: Oscillator times power-on, clears memory, feeds config clock
// R2: Oscillator runs at nominal 12 MHz
// R3: Config clock 1, 6 or 12 MHz, 1 MHz default
// R4: Divider source is oscillator or user clock
// R5: Fine output divides by 4, 16, 64, 256
// R6: Coarse output divides by 2 up to 65536
// R7: Each output has its own static ratio setting
// R8: Internal and user-clock divider variants exist
// R9: Counters clear on reset, outputs near even duty
module oscillator_clock_divider (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic userClock,
  output logic fineDividedClock,
  output logic coarseDividedClock,
  output logic configClockOut,
  output logic configMemClear,
  output logic powerOnDone
);
  import osc_div_pkg::*;

  osc_div_pkg::ctrl_t ctrl;
  osc_div_pkg::ctrl_t next_ctrl;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic setupPhase;
  logic writeCtrl;
  status_t status;

  logic [6:0] acc;
  logic [6:0] next_acc;
  logic oscLevel;
  logic next_oscLevel;
  logic halfTick;
  logic oscRise;
  logic [3:0] cfgCount;
  logic [3:0] next_cfgCount;
  logic [3:0] cfgLimit;
  logic cfgClk;
  logic next_cfgClk;
  logic next_configClockOut;
  por_state_t porState;
  por_state_t next_porState;
  logic [10:0] porCount;
  logic [10:0] next_porCount;

  logic userSync1;
  logic userSync2;
  logic userSync3;
  logic userLevel;
  logic next_userLevel;
  logic userRise;
  logic srcTick;

  // Zero wait states: read data is latched in the setup cycle
  assign pready = 1'b1;
  assign setupPhase = psel && !penable;
  assign writeCtrl = psel && penable && pwrite && paddr == ADDR_CTRL;
  assign status = '{configClk: configClockOut, coarseClk: coarseDividedClock,
                    fineClk: fineDividedClock, powerOnDone: powerOnDone};

  always_comb begin
    next_ctrl = ctrl;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (writeCtrl) begin
      next_ctrl = ctrl_t'(pwdata[CTRL_W-1:0]); // R7
    end
    if (setupPhase) begin
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (paddr == ADDR_CTRL) begin
        next_prdata = {{(32-CTRL_W){1'b0}}, ctrl};
      end else if (paddr == ADDR_STATUS) begin
        next_prdata = {{(32-STATUS_W){1'b0}}, status};
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET; // R3
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Oscillator modelled as a phase accumulator; edges jitter by one system cycle
  assign halfTick = (acc + ACC_STEP) >= ACC_WRAP; // R2
  assign oscRise = halfTick && !oscLevel;

  always_comb begin
    case (ctrl.cfgRate)
      RATE_MID: cfgLimit = CFG_TOG_MID;
      RATE_FAST: cfgLimit = CFG_TOG_FAST;
      default: cfgLimit = CFG_TOG_SLOW; // R3
    endcase
  end

  // The first synchroniser stage feeds only the second
  assign userRise = (userSync2 == userSync3) && userSync3 && !userLevel;
  assign srcTick = ctrl.userSource ? userRise : oscRise; // R4 R8

  always_comb begin
    next_acc = halfTick ? 7'(acc + ACC_STEP - ACC_WRAP) : 7'(acc + ACC_STEP); // R2
    next_oscLevel = halfTick ? ~oscLevel : oscLevel; // R1
    next_cfgCount = cfgCount;
    next_cfgClk = cfgClk;
    if (halfTick) begin
      if (cfgCount >= cfgLimit - 4'h1) begin // R3
        next_cfgCount = 4'h0;
        next_cfgClk = ~cfgClk;
      end else begin
        next_cfgCount = cfgCount + 4'h1;
      end
    end
    // Config clock is driven only while a master mode is active
    next_configClockOut = ctrl.masterMode && next_cfgClk; // R1
    next_userLevel = (userSync2 == userSync3) ? userSync3 : userLevel;
    next_porState = porState;
    next_porCount = porCount;
    case (porState)
      POR_CLEAR: begin
        if (oscRise) begin // R1
          if (porCount == POR_OSC_CYCLES - 11'h001) begin
            next_porState = POR_RUN;
          end else begin
            next_porCount = porCount + 11'h001;
          end
        end
      end
      POR_RUN: next_porState = POR_RUN;
      default: next_porState = POR_CLEAR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 7'h00;
      oscLevel <= 1'b0;
      cfgCount <= 4'h0;
      cfgClk <= 1'b0;
      configClockOut <= 1'b0;
      porState <= POR_CLEAR;
      porCount <= 11'h000;
      userSync1 <= 1'b0;
      userSync2 <= 1'b0;
      userSync3 <= 1'b0;
      userLevel <= 1'b0;
    end else begin
      acc <= next_acc;
      oscLevel <= next_oscLevel;
      cfgCount <= next_cfgCount;
      cfgClk <= next_cfgClk;
      configClockOut <= next_configClockOut;
      porState <= next_porState;
      porCount <= next_porCount;
      userSync1 <= userClock;
      userSync2 <= userSync1;
      userSync3 <= userSync2;
      userLevel <= next_userLevel;
    end
  end

  assign configMemClear = (porState == POR_CLEAR); // R1
  assign powerOnDone = (porState == POR_RUN);

  ratio_divider fineDiv (
    .clk(clk),
    .rst_n(rst_n),
    .tick(srcTick),
    .halfCount(fineHalf(ctrl.fineSel)), // R5 R7
    .divClk(fineDividedClock)
  );

  ratio_divider coarseDiv (
    .clk(clk),
    .rst_n(rst_n),
    .tick(srcTick),
    .halfCount(coarseHalf(ctrl.coarseSel)), // R6 R7
    .divClk(coarseDividedClock)
  );

  sequence halfTickGap;
    halfTick ##1 !halfTick [*3];
  endsequence

  AST_OSC_GAP: assert property (@(posedge clk) disable iff (!rst_n) // R2
    halfTickGap |-> ##[1:2] halfTick)
    else $error("oscillator half period is not 4 or 5 cycles");
  AST_POR_LENGTH: assert property (@(posedge clk) disable iff (!rst_n) // R1
    $rose(powerOnDone) |-> $past(porCount) == POR_OSC_CYCLES - 11'h001 && $past(oscRise))
    else $error("power-on delay ended at the wrong count");
  AST_CFG_GATED: assert property (@(posedge clk) disable iff (!rst_n) // R1
    !ctrl.masterMode |=> !configClockOut)
    else $error("config clock driven outside master mode");
  AST_CFG_FAST: assert property (@(posedge clk) disable iff (!rst_n) // R3
    ctrl.cfgRate == RATE_FAST && halfTick |=> cfgClk != $past(cfgClk))
    else $error("fast config clock missed a toggle");
  AST_CFG_SLOW: assert property (@(posedge clk) disable iff (!rst_n) // R3
    ctrl.cfgRate == RATE_SLOW && halfTick && cfgCount == 4'h0 |=> $stable(cfgClk))
    else $error("slow config clock toggled too early");
  AST_FINE_RATIO: assert property (@(posedge clk) disable iff (!rst_n) // R5
    fineHalf(ctrl.fineSel) inside {16'h0001, 16'h0007, 16'h001f, 16'h007f})
    else $error("fine ratio outside 4, 16, 64, 256");
  AST_COARSE_MAX: assert property (@(posedge clk) disable iff (!rst_n) // R6
    ctrl.coarseSel == 3'h7 |-> coarseHalf(ctrl.coarseSel) == 16'h7fff)
    else $error("coarse ratio 65536 wrong");
  AST_SETTING_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R7
    writeCtrl |=> ctrl.fineSel == $past(pwdata[5:4]) && ctrl.coarseSel == $past(pwdata[8:6]))
    else $error("divide setting not taken from write");
  // Watches the fine divider output itself, so a wrong source select in oscillator mode is caught
  AST_INTERNAL_VARIANT: assert property (@(posedge clk) disable iff (!rst_n) // R8
    !ctrl.userSource && $stable(ctrl.userSource) && $changed(fineDividedClock)
      |-> $past(halfTick && !oscLevel))
    else $error("internal variant moved without an oscillator rise");
endmodule : oscillator_clock_divider
`default_nettype wire

// >>> osc_div_pkg.sv
// Constants, register layout and types for the oscillator clock divider
`default_nettype none
package osc_div_pkg;
  localparam int SYS_CLK_MHZ = 100;
  localparam int OSC_NOM_MHZ = 12;
  // Oscillator half-periods per microsecond; the phase accumulator steps by this
  localparam int OSC_HALF_MHZ = 2 * OSC_NOM_MHZ;
  localparam logic [6:0] ACC_STEP = 7'(OSC_HALF_MHZ);
  localparam logic [6:0] ACC_WRAP = 7'(SYS_CLK_MHZ);
  localparam int CFG_MHZ_SLOW = 1;
  localparam int CFG_MHZ_MID = 6;
  localparam int CFG_MHZ_FAST = 12;
  // Oscillator half-periods between config clock toggles
  localparam logic [3:0] CFG_TOG_SLOW = 4'(OSC_HALF_MHZ / (2 * CFG_MHZ_SLOW));
  localparam logic [3:0] CFG_TOG_MID = 4'(OSC_HALF_MHZ / (2 * CFG_MHZ_MID));
  localparam logic [3:0] CFG_TOG_FAST = 4'(OSC_HALF_MHZ / (2 * CFG_MHZ_FAST));
  localparam logic [1:0] RATE_SLOW = 2'h0;
  localparam logic [1:0] RATE_MID = 2'h1;
  localparam logic [1:0] RATE_FAST = 2'h2;
  localparam logic [10:0] POR_OSC_CYCLES = 11'h400;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_W = 9;
  localparam int STATUS_W = 4;
  typedef struct packed {
    logic [2:0] coarseSel;
    logic [1:0] fineSel;
    logic masterMode;
    logic [1:0] cfgRate;
    logic userSource;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = ctrl_t'(9'h000);
  typedef struct packed {
    logic configClk;
    logic coarseClk;
    logic fineClk;
    logic powerOnDone;
  } status_t;
  typedef enum logic [1:0] {
    POR_CLEAR = 2'b01,
    POR_RUN = 2'b10
  } por_state_t;
  // Half of the ratio minus one, in source ticks
  function automatic logic [15:0] fineHalf(input logic [1:0] sel);
    fineHalf = 16'((32'h1 << (2 * sel + 1)) - 1);
  endfunction : fineHalf
  function automatic logic [15:0] coarseHalf(input logic [2:0] sel);
    logic [4:0] lg;
    case (sel)
      3'h0: lg = 5'h01;
      3'h1: lg = 5'h03;
      3'h2: lg = 5'h05;
      3'h3: lg = 5'h07;
      3'h4: lg = 5'h0a;
      3'h5: lg = 5'h0c;
      3'h6: lg = 5'h0e;
      default: lg = 5'h10;
    endcase
    coarseHalf = 16'((32'h1 << (lg - 5'h01)) - 1);
  endfunction : coarseHalf
endpackage : osc_div_pkg
`default_nettype wire

// >>> tb_oscillator_clock_divider.sv
// Self-checking testbench for the oscillator clock divider
`default_nettype none
module tb_oscillator_clock_divider;
  timeunit 1ns;
  timeprecision 100ps;
  import osc_div_pkg::*;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic userClock = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic fineDividedClock, coarseDividedClock, configClockOut, configMemClear, powerOnDone;
  int bad_count = 0;
  int compares = 0;
  int ucCnt = 0;
  int cr[8] = '{2, 8, 32, 128, 1024, 4096, 16384, 65536};
  int rateMhz[4] = '{1, 6, 12, 1};
  oscillator_clock_divider dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .userClock(userClock), .fineDividedClock(fineDividedClock),
    .coarseDividedClock(coarseDividedClock), .configClockOut(configClockOut),
    .configMemClear(configMemClear), .powerOnDone(powerOnDone));
  always #5 clk = ~clk;
  // User clock at clk/10, slow enough for the synchroniser to see every edge
  always @(posedge clk) begin
    ucCnt <= (ucCnt == 4) ? 0 : ucCnt + 1;
    if (ucCnt == 4) userClock <= ~userClock;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] mk(input logic [2:0] cs, input logic [1:0] fs,
      input logic mm, input logic [1:0] rt, input logic us);
    ctrl_t c;
    c = '{coarseSel: cs, fineSel: fs, masterMode: mm, cfgRate: rt, userSource: us};
    mk = 32'(c);
  endfunction : mk
  // Cycles spanned by nper periods (nper+1 rising edges) of the chosen output; tolerance covers osc jitter
  task measure(input int which, input int nper, input int exp);
    int n, t0, t, got;
    logic prev, cur;
    n = 0; t0 = 0; t = 0; got = -1; prev = 1'b1;
    while (n < nper + 1 && t < 30000) begin
      @(posedge clk);
      #1;
      cur = (which == 0) ? fineDividedClock : (which == 1) ? coarseDividedClock : configClockOut;
      if (cur === 1'b1 && prev === 1'b0) begin
        n++;
        if (n == 1) t0 = t;
        if (n == nper + 1) got = t - t0;
      end
      prev = cur;
      t++;
    end
    check(32'((got - exp <= 6 && exp - got <= 6) ? exp : got), 32'(exp));
  endtask : measure
  task t_power_on;
    int t;
    // Outputs hold their reset values, so they are read at the release edge
    check({configMemClear, powerOnDone, fineDividedClock}, 3'b100);
    check({coarseDividedClock, configClockOut}, 2'b00);
    rst_n <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      #1;
      t++;
    end while (powerOnDone !== 1'b1 && t < 12000);
    // 1024 cycles of a 12 MHz oscillator
    check(32'((t > 8523 && t < 8543) ? 8533 : t), 32'd8533);
    check(configMemClear, 1'b0);
  endtask : t_power_on
  task t_regs;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdata, 32'h0);
    check({rerr, pready}, 2'b01);
    apb(1'b1, ADDR_CTRL, 32'hffffffff);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdata, 32'h000001ff);
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({rerr, rdata[0]}, 2'b01);
    apb(1'b1, 8'h10, 32'h0);
    check(rerr, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    check(rerr, 1'b1);
    check(rdata, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdata, 32'h000001ff);
  endtask : t_regs
  task t_dividers;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ADDR_CTRL, mk(3'h7, 2'(s), 1'b0, 2'h0, 1'b0));
      measure(0, 3, (4 << (2 * s)) * 25);
    end
    for (int s = 0; s < 5; s++) begin
      apb(1'b1, ADDR_CTRL, mk(3'(s), 2'h3, 1'b0, 2'h0, 1'b0));
      measure(1, (s < 4) ? 3 : 1, ((s < 4) ? 3 : 1) * cr[s] * 100 / 12);
    end
  endtask : t_dividers
  task t_config_clock;
    int hi;
    apb(1'b1, ADDR_CTRL, mk(3'h0, 2'h0, 1'b0, 2'h2, 1'b0));
    hi = 0;
    repeat (200) begin
      @(posedge clk);
      #1;
      if (configClockOut !== 1'b0) hi++;
    end
    check(32'(hi), 32'd0);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, ADDR_CTRL, mk(3'h0, 2'h0, 1'b1, 2'(r), 1'b0));
      measure(2, 6, 600 / rateMhz[r]);
    end
  endtask : t_config_clock
  task t_user_source;
    apb(1'b1, ADDR_CTRL, mk(3'h0, 2'h0, 1'b0, 2'h0, 1'b1));
    measure(0, 3, 120);
    measure(1, 3, 60);
  endtask : t_user_source
  task t_mid_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    check({fineDividedClock, coarseDividedClock, configMemClear}, 3'b001);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdata, 32'h0);
  endtask : t_mid_reset
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    repeat (12) @(posedge clk);
    t_power_on();
    t_regs();
    t_dividers();
    t_config_clock();
    t_user_source();
    t_mid_reset();
    end_sim();
  end
  // Whole run is about 40k cycles
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule : tb_oscillator_clock_divider
`default_nettype wire
